// ---- logic/lls_pixel_clock_ctrl.sv ----
// control logic of the line-locked pixel clock generator
// assumes clk is the pixel clock domain and pins are asynchronous
`timescale 1ns/100ps
module lls_pixel_clock_ctrl #(
	parameter int TAIL_LINES = lls_pkg::HOLD_TAIL_LINES
) (
	input  wire logic          clk,         // pixel domain clock
	input  wire logic          rst,         // asynchronous reset
	input  wire logic [7:0]    regAddr,     // register offset
	input  wire logic [7:0]    regWrData,   // write data
	input  wire logic          regWrEn,     // write strobe
	output logic      [7:0]    regRdData,   // read data, one cycle late
	input  wire logic          lineSyncIn,  // horizontal sync pin
	input  wire logic          holdIn,      // hold pin
	input  wire logic          vsyncIn,     // vertical sync pin
	output logic               pumpUp,      // raise oscillator frequency
	output logic               pumpDown,    // lower oscillator frequency
	output logic               fbPulse,     // divided clock pulse
	output lls_pkg::lls_analog_t analogCfg, // band, pump, phase, source
	output logic               phaseMatchedLineSyncOut, // sync copy
	output logic               holdActive   // loop is holding
);

	// configuration registers
	logic [11:0] div_r;
	logic [1:0]  band_r;
	logic [2:0]  pump_r;
	logic [4:0]  phase_r;
	logic [1:0]  hsPol_r;
	logic [1:0]  holdPol_r;
	logic        holdInt_r;
	logic        extClk_r;
	logic [7:0]  rdData_r;

	// write decode
	wire wrDivHi  = regWrEn && regAddr == lls_pkg::DIV_HI_ADDR;
	wire wrDivLo  = regWrEn && regAddr == lls_pkg::DIV_LO_ADDR;
	wire wrLoop   = regWrEn && regAddr == lls_pkg::LOOP_ADDR;
	wire wrPhase  = regWrEn && regAddr == lls_pkg::PHASE_ADDR;
	wire wrCtrl   = regWrEn && regAddr == lls_pkg::CTRL_ADDR;
	wire wrHsPol  = regWrEn && regAddr == lls_pkg::HS_POL_ADDR;
	wire wrHoldPl = regWrEn && regAddr == lls_pkg::HOLD_POL_ADDR;

	// register storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r     <= lls_pkg::DIV_RST;
			band_r    <= lls_pkg::BAND_RST;
			pump_r    <= lls_pkg::PUMP_RST;
			phase_r   <= lls_pkg::PHASE_RST;
			hsPol_r   <= lls_pkg::POL_RST;
			holdPol_r <= lls_pkg::POL_RST;
			holdInt_r <= 1'b0;
			extClk_r  <= 1'b0;
		end else begin
			if (wrDivHi)
				div_r[11:4] <= regWrData;
			if (wrDivLo)
				div_r[3:0] <= regWrData[lls_pkg::DIV_LO_POS +: 4];
			if (wrLoop) begin
				band_r <= regWrData[lls_pkg::BAND_POS +: 2];
				pump_r <= regWrData[lls_pkg::PUMP_POS +: 3];
			end
			if (wrPhase)
				phase_r <= regWrData[lls_pkg::PHASE_POS +: 5];
			if (wrCtrl) begin
				holdInt_r <= regWrData[lls_pkg::HOLD_INT_POS];
				extClk_r  <= regWrData[lls_pkg::EXT_CLK_POS];
			end
			if (wrHsPol)
				hsPol_r <= regWrData[lls_pkg::HS_POL_POS +: 2];
			if (wrHoldPl)
				holdPol_r <= regWrData[lls_pkg::HOLD_POL_POS +: 2];
		end
	end

	// sync conditioning of the three pins
	logic hsLevel;
	logic hsRise;
	logic holdPinLevel;
	logic vsLevel;

	lls_sync_cond uHsCond (
		.clk        (clk),
		.rst        (rst),
		.pinIn      (lineSyncIn),
		.activeHigh (hsPol_r[0]),
		.level      (hsLevel),
		.rise       (hsRise)
	);

	lls_sync_cond uHoldCond (
		.clk        (clk),
		.rst        (rst),
		.pinIn      (holdIn),
		.activeHigh (holdPol_r[0]),
		.level      (holdPinLevel),
		.rise       ()
	);

	// vertical sync is taken as active high
	lls_sync_cond uVsCond (
		.clk        (clk),
		.rst        (rst),
		.pinIn      (vsyncIn),
		.activeHigh (1'b1),
		.level      (vsLevel),
		.rise       ()
	);

	// internal hold: vertical sync plus a tail of lines after it
	logic [7:0] tail_r;
	wire  [7:0] tailLoad = 8'(TAIL_LINES);
	wire  [7:0] tail_nxt = vsLevel ? tailLoad :
		(hsRise && tail_r != 8'h00) ? tail_r - 8'h01 : tail_r;
	wire  holdIntLevel = vsLevel || tail_r != 8'h00;
	wire  hold = holdInt_r ? holdIntLevel : holdPinLevel;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tail_r <= 8'h00;
		else
			tail_r <= tail_nxt;
	end

	// feedback divider; divisor below the minimum is clamped
	logic [11:0] fbCnt_r;
	wire  [11:0] divEff  = (div_r < lls_pkg::DIV_MIN) ? lls_pkg::DIV_MIN
		: div_r;
	wire         fbWrap  = fbCnt_r >= divEff - 12'h001;
	wire  [11:0] fbCnt_nxt = fbWrap ? 12'h000 : fbCnt_r + 12'h001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fbCnt_r <= 12'h000;
		else
			fbCnt_r <= fbCnt_nxt;
	end

	// phase detector: reference edge against divided edge
	lls_pkg::lls_pd_t pd_r;
	lls_pkg::lls_pd_t pd_nxt;

	always_comb begin
		pd_nxt = pd_r;
		if (hold) begin
			pd_nxt = lls_pkg::LLS_PD_IDLE;
		end else begin
			case (pd_r)
			lls_pkg::LLS_PD_IDLE: begin
				if (hsRise && !fbWrap)
					pd_nxt = lls_pkg::LLS_PD_UP;
				else if (fbWrap && !hsRise)
					pd_nxt = lls_pkg::LLS_PD_DOWN;
			end
			lls_pkg::LLS_PD_UP: begin
				if (fbWrap)
					pd_nxt = lls_pkg::LLS_PD_IDLE;
			end
			lls_pkg::LLS_PD_DOWN: begin
				if (hsRise)
					pd_nxt = lls_pkg::LLS_PD_IDLE;
			end
			default: pd_nxt = lls_pkg::LLS_PD_IDLE;
			endcase
		end
	end

	// loop outputs and the phase-matched sync copy
	logic pumpUp_r;
	logic pumpDown_r;
	logic fbPulse_r;
	logic phase_matched_line_sync_out_r;
	logic hold_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pd_r       <= lls_pkg::LLS_PD_IDLE;
			pumpUp_r   <= 1'b0;
			pumpDown_r <= 1'b0;
			fbPulse_r  <= 1'b0;
			phase_matched_line_sync_out_r    <= 1'b0;
			hold_r     <= 1'b0;
		end else begin
			pd_r       <= pd_nxt;
			pumpUp_r   <= pd_nxt == lls_pkg::LLS_PD_UP;
			pumpDown_r <= pd_nxt == lls_pkg::LLS_PD_DOWN;
			fbPulse_r  <= fbWrap;
			phase_matched_line_sync_out_r    <= hsLevel;
			hold_r     <= hold;
		end
	end

	// analog settings; phase stays live for either clock source
	assign analogCfg.band   = lls_pkg::lls_band_t'(band_r);
	assign analogCfg.pump   = lls_pkg::lls_pump_t'(pump_r);
	assign analogCfg.phase  = phase_r;
	assign analogCfg.extClk = extClk_r;

	assign pumpUp                  = pumpUp_r;
	assign pumpDown                = pumpDown_r;
	assign fbPulse                 = fbPulse_r;
	assign phaseMatchedLineSyncOut = phase_matched_line_sync_out_r;
	assign holdActive              = hold_r;

	// read mux, unmapped offsets read zero
	logic [7:0] rdMux;
	always_comb begin
		case (regAddr)
		lls_pkg::DIV_HI_ADDR:   rdMux = div_r[11:4];
		lls_pkg::DIV_LO_ADDR:   rdMux = {div_r[3:0], 4'h0};
		lls_pkg::LOOP_ADDR:     rdMux = {band_r, pump_r, 3'h0};
		lls_pkg::PHASE_ADDR:    rdMux = {phase_r, 3'h0};
		lls_pkg::CTRL_ADDR:     rdMux = {6'h00, extClk_r, holdInt_r};
		lls_pkg::STAT_ADDR:     rdMux = {5'h00, pumpDown_r, pumpUp_r,
			hold_r};
		lls_pkg::HS_POL_ADDR:   rdMux = {2'h0, hsPol_r, 4'h0};
		lls_pkg::HOLD_POL_ADDR: rdMux = {1'b0, holdPol_r, 5'h00};
		default:                rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdData_r <= 8'h00;
		else
			rdData_r <= rdMux;
	end

	assign regRdData = rdData_r;

endmodule : lls_pixel_clock_ctrl

// ---- logic/lls_pkg.sv ----
// constants and types for the line-locked pixel clock control
// assumes an 8-bit register port with byte-wide offsets
package lls_pkg;

	// register offsets
	localparam logic [7:0] DIV_HI_ADDR   = 8'h01; // divisor bits 11:4
	localparam logic [7:0] DIV_LO_ADDR   = 8'h02; // divisor bits 3:0 in 7:4
	localparam logic [7:0] LOOP_ADDR     = 8'h03; // band and pump
	localparam logic [7:0] PHASE_ADDR    = 8'h04; // sampling phase
	localparam logic [7:0] CTRL_ADDR     = 8'h05; // hold source, clock source
	localparam logic [7:0] STAT_ADDR     = 8'h06; // loop status, read only
	localparam logic [7:0] HS_POL_ADDR   = 8'h12; // line sync polarity
	localparam logic [7:0] HOLD_POL_ADDR = 8'h18; // hold polarity

	// field positions
	localparam int DIV_LO_POS   = 4;
	localparam int BAND_POS     = 6;
	localparam int PUMP_POS     = 3;
	localparam int PHASE_POS    = 3;
	localparam int HS_POL_POS   = 4; // field 5:4
	localparam int HOLD_POL_POS = 5; // field 6:5
	localparam int HOLD_INT_POS = 0;
	localparam int EXT_CLK_POS  = 1;

	// values after reset, and the smallest divisor
	localparam logic [11:0] DIV_RST   = 12'h0_400;
	localparam logic [1:0]  BAND_RST  = 2'h1;
	localparam logic [2:0]  PUMP_RST  = 3'h4;
	localparam logic [4:0]  PHASE_RST = 5'h00;
	localparam logic [1:0]  POL_RST   = 2'h1;
	localparam logic [11:0] DIV_MIN   = 12'h0_002;

	// lines of hold kept after vertical sync ends
	localparam int HOLD_TAIL_LINES = 4;

	// oscillator band codes
	typedef enum logic [1:0] {
		LLS_BAND_10_21 = 2'h0,
		LLS_BAND_21_42 = 2'h1,
		LLS_BAND_42_84 = 2'h2,
		LLS_BAND_84_95 = 2'h3
	} lls_band_t;

	// pump current codes, microamps in the names
	typedef enum logic [2:0] {
		LLS_PUMP_50   = 3'h0,
		LLS_PUMP_100  = 3'h1,
		LLS_PUMP_150  = 3'h2,
		LLS_PUMP_250  = 3'h3,
		LLS_PUMP_350  = 3'h4,
		LLS_PUMP_500  = 3'h5,
		LLS_PUMP_750  = 3'h6,
		LLS_PUMP_1500 = 3'h7
	} lls_pump_t;

	// phase detector states, gray along idle-up-idle-down
	typedef enum logic [1:0] {
		LLS_PD_IDLE = 2'b00,
		LLS_PD_UP   = 2'b01,
		LLS_PD_DOWN = 2'b10
	} lls_pd_t;

	// settings handed to the analog loop
	typedef struct packed {
		lls_band_t  band;
		lls_pump_t  pump;
		logic [4:0] phase;
		logic       extClk;
	} lls_analog_t;

endpackage : lls_pkg

// ---- logic/lls_sync_cond.sv ----
// synchroniser, polarity normaliser and rising-edge detector for one pin
// assumes an asynchronous pin and one clock domain
`timescale 1ns/100ps
module lls_sync_cond (
	input  wire logic clk,        // system clock
	input  wire logic rst,        // asynchronous reset, active high
	input  wire logic pinIn,      // raw pin level
	input  wire logic activeHigh, // 1: pin is active high
	output logic      level,      // normalised level, active high
	output logic      rise        // one-cycle pulse on assertion
);

	logic meta_r;
	logic sync_r;
	logic level_r;

	// two-flop synchroniser, then normalised level register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r  <= 1'b0;
			sync_r  <= 1'b0;
			level_r <= 1'b0;
		end else begin
			meta_r  <= pinIn;
			sync_r  <= meta_r;
			level_r <= sync_r ~^ activeHigh;
		end
	end

	// edge from the normalised copy only
	wire levelNow = sync_r ~^ activeHigh;
	assign level = level_r;
	assign rise  = levelNow & ~level_r;

endmodule : lls_sync_cond

// ---- test/lls_ctrl_checker.sv ----
// port assertions for the pixel clock control
// assumes a bind onto lls_pixel_clock_ctrl, single clock domain
`timescale 1ns/100ps
module lls_ctrl_checker (
	input wire logic                 clk,        // clock
	input wire logic                 rst,        // reset
	input wire logic [7:0]           regAddr,    // offset
	input wire logic [7:0]           regWrData,  // write data
	input wire logic                 regWrEn,    // write strobe
	input wire logic [7:0]           regRdData,  // read data
	input wire logic                 pumpUp,     // pump up
	input wire logic                 pumpDown,   // pump down
	input wire logic                 fbPulse,    // divider wrap
	input wire lls_pkg::lls_analog_t analogCfg,  // analog settings
	input wire logic                 holdActive  // holding
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// decoded register writes
	wire loopWr  = regWrEn && regAddr == lls_pkg::LOOP_ADDR;
	wire phaseWr = regWrEn && regAddr == lls_pkg::PHASE_ADDR;
	wire ctrlWr  = regWrEn && regAddr == lls_pkg::CTRL_ADDR;
	wire hsPolWr = regWrEn && regAddr == lls_pkg::HS_POL_ADDR;
	wire hdPolWr = regWrEn && regAddr == lls_pkg::HOLD_POL_ADDR;
	// loop outputs
	a_pump_exclusive: assert property (
		!(pumpUp && pumpDown)) else $error("pump both ways");
	a_fb_single: assert property (
		fbPulse |=> !fbPulse) else $error("divider pulse too long");
	a_hold_quiet: assert property (
		holdActive [*2] |-> !pumpUp && !pumpDown) else $error("pump in hold");
	// register fields reach the analog settings
	a_band_write: assert property (
		loopWr |=> analogCfg.band == $past(regWrData[7:6]))
		else $error("band not taken");
	a_pump_write: assert property (
		loopWr |=> analogCfg.pump == $past(regWrData[5:3]))
		else $error("pump code not taken");
	a_phase_write: assert property (
		phaseWr |=> analogCfg.phase == $past(regWrData[7:3]))
		else $error("phase not taken");
	a_ext_clk: assert property (
		ctrlWr |=> analogCfg.extClk == $past(regWrData[1]))
		else $error("clock source not taken");
	// polarity fields read back
	a_hs_pol_read: assert property (
		hsPolWr ##1 (regAddr == lls_pkg::HS_POL_ADDR && !regWrEn)
		|=> regRdData[5:4] == $past(regWrData[5:4], 2))
		else $error("line sync polarity readback");
	a_hold_pol_read: assert property (
		hdPolWr ##1 (regAddr == lls_pkg::HOLD_POL_ADDR && !regWrEn)
		|=> regRdData[6:5] == $past(regWrData[6:5], 2))
		else $error("hold polarity readback");
	// main scenarios
	c_fb_pulse: cover property (fbPulse);
	c_pump_up: cover property (pumpUp);
	c_hold_end: cover property (holdActive ##1 !holdActive);
endmodule : lls_ctrl_checker

// ---- test/lls_pixel_clock_ctrl_tb_top.sv ----
// self-checking bench for the pixel clock control
// assumes the checker and video source model compile first
`timescale 1ns/100ps
module lls_pixel_clock_ctrl_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic run = 1'b0, syncHigh = 1'b1, holdOn = 1'b0;
	logic holdHigh = 1'b1, vsyncOn = 1'b0, pumpSeen = 1'b0;
	logic upSeen = 1'b0, downSeen = 1'b0;
	logic [7:0] regRdData;
	logic lineSyncIn, holdIn, vsyncIn, pumpUp, pumpDown;
	logic fbPulse, syncOut, holdActive;
	lls_pkg::lls_analog_t analogCfg;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;

	lls_pixel_clock_ctrl #(.TAIL_LINES(1)) lls_pixel_clock_ctrl_inst (
		.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdData(regRdData), .lineSyncIn(lineSyncIn),
		.holdIn(holdIn), .vsyncIn(vsyncIn), .pumpUp(pumpUp),
		.pumpDown(pumpDown), .fbPulse(fbPulse), .analogCfg(analogCfg),
		.phaseMatchedLineSyncOut(syncOut), .holdActive(holdActive));
	lls_video_src lls_video_src_inst (
		.clk(clk), .run(run), .syncHigh(syncHigh), .holdOn(holdOn),
		.holdHigh(holdHigh), .vsyncOn(vsyncOn), .lineSync(lineSyncIn),
		.hold(holdIn), .vsync(vsyncIn));

	// clock and hang guard
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [7:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk);
		regWrEn = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, m, e, input string what);
		@(negedge clk);
		regAddr = a;
		@(negedge clk);
		chk(regRdData & m, e, what);
	endtask : rd

	// run n cycles and note any pump activity
	task automatic watch(input int n);
		repeat (n) begin
			@(negedge clk);
			pumpSeen |= pumpUp | pumpDown;
			upSeen |= pumpUp;
			downSeen |= pumpDown;
		end
	endtask : watch

	task automatic t_resets();
		chk({6'h00, analogCfg.band}, 8'h01, "band rst");
		chk({5'h00, analogCfg.pump}, 8'h04, "pump rst");
		chk({3'h0, analogCfg.phase}, 8'h00, "phase rst");
		rd(lls_pkg::DIV_HI_ADDR, 8'hff, 8'h40, "div hi rst");
		rd(lls_pkg::DIV_LO_ADDR, 8'hf0, 8'h00, "div lo rst");
		rd(lls_pkg::HS_POL_ADDR, 8'h30, 8'h10, "hs pol rst");
		rd(lls_pkg::HOLD_POL_ADDR, 8'h60, 8'h20, "hold pol rst");
		rd(8'h40, 8'hff, 8'h00, "unmapped");
	endtask : t_resets

	task automatic t_fields();
		for (int i = 0; i < 8; i++) begin
			wr(lls_pkg::LOOP_ADDR, {i[1:0], i[2:0], 3'h0});
			chk({6'h00, analogCfg.band}, {6'h00, i[1:0]}, "band");
			chk({5'h00, analogCfg.pump}, {5'h00, i[2:0]}, "pump");
		end
		for (int i = 0; i < 32; i++) begin
			wr(lls_pkg::PHASE_ADDR, {i[4:0], 3'h0});
			chk({3'h0, analogCfg.phase}, {3'h0, i[4:0]}, "phase");
		end
		wr(lls_pkg::CTRL_ADDR, 8'h02);
		chk({2'h0, analogCfg.phase, analogCfg.extClk}, 8'h3f, "ext");
		wr(lls_pkg::CTRL_ADDR, 8'h00);
	endtask : t_fields

	task automatic t_divider(input logic [11:0] d);
		int n;
		wr(lls_pkg::DIV_HI_ADDR, d[11:4]);
		wr(lls_pkg::DIV_LO_ADDR, {d[3:0], 4'h0});
		repeat (3) begin
			@(negedge clk);
			for (n = 1; n < 5000 && fbPulse !== 1'b1; n++) @(negedge clk);
		end
		chk(8'(n), d[7:0], "divider period");
		chk(8'(n >> 8), {4'h0, d[11:8]}, "divider period hi");
	endtask : t_divider

	task automatic t_sync_copy(input logic pol);
		run = 1'b0;
		wr(lls_pkg::HS_POL_ADDR, {3'h0, pol, 4'h0});
		rd(lls_pkg::HS_POL_ADDR, 8'h30, {3'h0, pol, 4'h0}, "hs pol");
		syncHigh = pol;
		// let the polarity switch flush through the synchroniser
		watch(6);
		chk({7'h00, syncOut}, 8'h00, "sync copy quiet");
		run = 1'b1;
		for (int n = 0; n < 100 && syncOut !== 1'b1; n++) @(negedge clk);
		chk({7'h00, syncOut}, 8'h01, "sync copy");
		pumpSeen = 1'b0;
		downSeen = 1'b0;
		watch(20);
		chk({7'h00, syncOut}, 8'h00, "sync copy idle");
		watch(40);
		chk({7'h00, pumpSeen}, 8'h01, "loop pumps");
		chk({7'h00, downSeen}, 8'h01, "loop pumps down");
	endtask : t_sync_copy

	task automatic t_hold_pin();
		wr(lls_pkg::HOLD_POL_ADDR, 8'h00);
		rd(lls_pkg::HOLD_POL_ADDR, 8'h60, 8'h00, "hold pol");
		holdHigh = 1'b0;
		holdOn = 1'b1;
		watch(6);
		chk({7'h00, holdActive}, 8'h01, "hold low pin");
		pumpSeen = 1'b0;
		watch(80);
		chk({7'h00, pumpSeen}, 8'h00, "pump in hold");
		holdOn = 1'b0;
		watch(6);
		chk({7'h00, holdActive}, 8'h00, "hold released");
	endtask : t_hold_pin

	task automatic t_hold_vsync();
		wr(lls_pkg::CTRL_ADDR, 8'h01);
		vsyncOn = 1'b1;
		watch(6);
		chk({7'h00, holdActive}, 8'h01, "vsync hold");
		for (int n = 0; n < 100 && syncOut !== 1'b1; n++) @(negedge clk);
		watch(6);
		vsyncOn = 1'b0;
		watch(10);
		chk({7'h00, holdActive}, 8'h01, "hold tail");
		watch(50);
		chk({7'h00, holdActive}, 8'h00, "tail over");
	endtask : t_hold_vsync

	// recommended setting of the fastest graphics mode, loop pumps up
	task automatic t_format();
		wr(lls_pkg::CTRL_ADDR, 8'h00);
		wr(lls_pkg::LOOP_ADDR, 8'he0);
		chk({6'h00, analogCfg.band}, 8'h03, "format band");
		chk({5'h00, analogCfg.pump}, 8'h04, "format pump");
		t_divider(12'h560);
		upSeen = 1'b0;
		watch(100);
		chk({7'h00, upSeen}, 8'h01, "loop pumps up");
	endtask : t_format

	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_resets();
		t_fields();
		t_divider(12'h002);
		t_divider(12'h00d);
		t_sync_copy(1'b1);
		t_sync_copy(1'b0);
		t_hold_pin();
		t_hold_vsync();
		t_format();
		finish_test();
	end
endmodule : lls_pixel_clock_ctrl_tb_top

bind lls_pixel_clock_ctrl lls_ctrl_checker lls_ctrl_checker_inst (
	.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
	.regWrEn(regWrEn), .regRdData(regRdData), .pumpUp(pumpUp),
	.pumpDown(pumpDown), .fbPulse(fbPulse), .analogCfg(analogCfg),
	.holdActive(holdActive));

// ---- test/lls_video_src.sv ----
// video source model: line sync, hold pin and vertical sync
// assumes the bench steers it from the falling clock edge
`timescale 1ns/100ps
module lls_video_src #(
	parameter int LINE_CLKS = 40 // clocks per line
) (
	input wire logic clk,      // clock
	input wire logic run,      // line sync running
	input wire logic syncHigh, // line sync active high
	input wire logic holdOn,   // hold requested
	input wire logic holdHigh, // hold active high
	input wire logic vsyncOn,  // vertical sync
	output logic     lineSync, // line sync pin
	output logic     hold,     // hold pin
	output logic     vsync     // vertical sync pin
);
	logic [7:0] lineCnt_r = 8'h00;
	wire  [7:0] lineLast = 8'(LINE_CLKS - 1);
	// line counter, pulse in the first four clocks
	always @(negedge clk)
		lineCnt_r <= (lineCnt_r == lineLast) ? 8'h00 : lineCnt_r + 8'h01;
	// line sync and hold pins at the chosen polarity, vertical sync as given
	assign lineSync = (run && lineCnt_r < 8'h04) ~^ syncHigh;
	assign hold = holdOn ~^ holdHigh;
	assign vsync = vsyncOn;
endmodule : lls_video_src
